// [logic/sapsc_top.sv]
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Alternate-map status and control of the serial port, with break
// transmit, break detect and transmit bit-error checking.
module sapsc_top (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rxd_pin,
   output logic             txd_pin_o,
   output logic             txd_pin_oe,
   input  wire logic [12:0] baud_div,
   input  wire logic        tx_data_bit,
   input  wire logic        tx_busy,
   input  wire logic        tx_empty_flag,
   input  wire logic        tx_done_flag,
   input  wire logic        rx_full_flag,
   input  wire logic        overrun_flag,
   input  wire logic        idle_flag,
   input  wire logic        wakeup_event,
   output logic             bit_strobe,
   output logic             tx_enable,
   output logic             rx_enable,
   output logic             rx_standby,
   output logic             idle_preamble_req,
   output logic             irq_req
);
   import sapsc_pkg::*;

   // --------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------
   logic        ack_q;
   logic [7:0]  alt_irq_q;
   logic [7:0]  alt_ebc_q;
   logic [7:0]  ctrl2_q;
   logic [7:0]  aux_q;
   logic        rx_edge_flag_q;
   logic        bit_error_flag_q;
   logic        bit_error_value_q;
   logic        break_seen_flag_q;
   logic        rx_meta_q;
   logic        rx_sync_q;
   logic        rx_prev_q;
   logic [3:0]  tick_idx_q;
   sapsc_brk_e  brk_state_q;
   logic [3:0]  brk_left_q;
   logic [7:0]  bkd_cnt_q;
   logic        txd_q;
   logic        txd_oe_q;
   logic        te_prev_q;
   logic        preamble_q;
   logic        irq_q;
   logic [31:0] rdata_q;

   logic        tick;
   logic        wr_fire;
   logic        rd_load;
   logic [2:0]  idx;
   logic [7:0]  wd;
   logic        alt_map_select;
   logic        rx_polarity;
   logic        long_break_sel;
   logic        char_len_sel;
   logic        rx_lvl;
   logic        edge_evt;
   logic        berr_evt;
   logic        bkd_evt;
   logic        samp_pt;
   logic [3:0]  brk_len;
   logic [7:0]  bkd_lim;
   logic        wr_stat;
   logic        irq_d;
   logic [7:0]  rd_mux;
   sapsc_berr_e bit_error_mode;

   assign idx            = avs_address[4:2];
   assign wd             = avs_writedata[7:0];
   assign alt_map_select = aux_q[B_ALT_MAP_SELECT];
   assign rx_polarity    = aux_q[B_RX_POLARITY];
   assign char_len_sel   = aux_q[B_CLEN];
   assign long_break_sel = aux_q[B_LBRK];
   assign bit_error_mode = sapsc_berr_e'(alt_ebc_q[B_BMODE +: 2]);
   assign tx_enable      = ctrl2_q[B_TE];
   assign rx_enable      = ctrl2_q[B_RE];
   assign rx_standby     = ctrl2_q[B_RWU];

   // --------------------------------------------------------------
   // Bus slave
   // --------------------------------------------------------------
   // One wait state: the answer comes on the second edge of a request.
   assign avs_waitrequest = (avs_read || avs_write) && !(ack_q && ce);
   assign wr_fire = avs_write && ack_q && ce && avs_byteenable[0];
   assign rd_load = avs_read && !ack_q && ce;
   assign wr_stat = wr_fire && alt_map_select && idx == IDX_ALT_STAT;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else if (ce) begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   // Alternate registers hide behind the map select; they read zero.
   always_comb begin
      rd_mux = 8'h00;
      unique case (idx)
         IDX_ALT_STAT: if (alt_map_select) begin
            rd_mux[B_RXEDG] = rx_edge_flag_q;
            rd_mux[B_BIT_ERROR_VALUE] = bit_error_value_q;
            rd_mux[B_BERRF] = bit_error_flag_q;
            rd_mux[B_BKDF]  = break_seen_flag_q;
         end
         IDX_ALT_IRQ: if (alt_map_select) begin
            rd_mux = alt_irq_q;
         end
         IDX_ALT_EBC: if (alt_map_select) begin
            rd_mux = alt_ebc_q;
         end
         IDX_CTRL2: rd_mux = ctrl2_q;
         IDX_AUX:   rd_mux = aux_q;
         IDX_STATE: rd_mux = {5'h00, irq_q, txd_q, brk_state_q};
         default:   rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_load) begin
         rdata_q <= {24'h00_0000, rd_mux};
      end
   end
   assign avs_readdata = rdata_q;

   // --------------------------------------------------------------
   // Control registers
   // --------------------------------------------------------------
   // Alternate control is written only in the alternate map.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         alt_irq_q <= RST_ALT_IRQ;
         alt_ebc_q <= RST_ALT_EBC;
         aux_q     <= RST_AUX;
      end else if (wr_fire) begin
         if (alt_map_select && idx == IDX_ALT_IRQ) begin
            alt_irq_q <= wd & MSK_ALT_IRQ;
         end
         if (alt_map_select && idx == IDX_ALT_EBC) begin
            alt_ebc_q <= wd & MSK_ALT_EBC;
         end
         if (idx == IDX_AUX) begin
            aux_q <= wd & MSK_AUX;
         end
      end
   end

   // Hardware wakeup clears standby; a write in that cycle wins.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl2_q <= RST_CTRL2;
      end else if (wr_fire && idx == IDX_CTRL2) begin
         ctrl2_q <= wd;
      end else if (ce && wakeup_event) begin
         ctrl2_q[B_RWU] <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // Receive pin synchroniser and edge detect
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else if (ce) begin
         rx_meta_q <= rxd_pin;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   assign rx_lvl   = rx_sync_q ^ rx_polarity;
   assign edge_evt = rx_polarity ? (rx_sync_q && !rx_prev_q)
                                 : (!rx_sync_q && rx_prev_q);

   // --------------------------------------------------------------
   // Bit timing
   // --------------------------------------------------------------
   sapsc_tick_gen sapsc_tick_gen_i (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .ce       (ce),
      .run      (tx_enable || rx_enable),
      .baud_div (baud_div),
      .tick     (tick)
   );

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tick_idx_q <= 4'h0;
      end else if (ce && tick) begin
         tick_idx_q <= tick_idx_q + 4'h1;
      end
   end
   assign bit_strobe = ce && tick && tick_idx_q == TICK_LAST;

   // --------------------------------------------------------------
   // Break transmit
   // --------------------------------------------------------------
   // Length follows character length and the long-break select.
   always_comb begin
      unique case ({long_break_sel, char_len_sel})
         2'b00: brk_len = BRK_LEN_8;
         2'b01: brk_len = BRK_LEN_9;
         2'b10: brk_len = BRK_LONG_8;
         2'b11: brk_len = BRK_LONG_9;
      endcase
   end

   // A break starts on a bit boundary once the shifter is idle and,
   // once started, runs whole even if the request is withdrawn.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         brk_state_q <= BRK_IDLE;
         brk_left_q  <= 4'h0;
      end else if (ce) begin
         if (!tx_enable) begin
            brk_state_q <= BRK_IDLE;
         end else if (bit_strobe) begin
            unique case (brk_state_q)
               BRK_IDLE: if (ctrl2_q[B_SBK] && !tx_busy) begin
                  brk_state_q <= BRK_SEND;
                  brk_left_q  <= brk_len;
               end
               BRK_SEND: if (brk_left_q != 4'h1) begin
                  brk_left_q <= brk_left_q - 4'h1;
               end else if (ctrl2_q[B_SBK]) begin
                  brk_left_q <= brk_len;
               end else begin
                  brk_state_q <= BRK_IDLE;
               end
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // Transmit pin
   // --------------------------------------------------------------
   // The port owns the pin only while the transmitter is enabled.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         txd_q    <= 1'b1;
         txd_oe_q <= 1'b0;
      end else if (ce) begin
         txd_oe_q <= tx_enable;
         if (brk_state_q == BRK_SEND) begin
            txd_q <= 1'b0;
         end else begin
            txd_q <= tx_busy ? tx_data_bit : 1'b1;
         end
      end
   end
   assign txd_pin_o  = txd_q;
   assign txd_pin_oe = txd_oe_q;

   // Enabling the transmitter asks the shifter for an idle preamble.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         te_prev_q  <= 1'b0;
         preamble_q <= 1'b0;
      end else if (ce) begin
         te_prev_q  <= tx_enable;
         preamble_q <= tx_enable && !te_prev_q;
      end
   end
   assign idle_preamble_req = preamble_q;

   // --------------------------------------------------------------
   // Bit-error check
   // --------------------------------------------------------------
   // The reserved mode code checks nothing, like the off code.
   always_comb begin
      unique case (bit_error_mode)
         BERR_T9:  samp_pt = tick_idx_q == TICK_NINE;
         BERR_T13: samp_pt = tick_idx_q == TICK_THIRT;
         default:  samp_pt = 1'b0;
      endcase
   end
   assign berr_evt = ce && tick && samp_pt && tx_enable &&
                     (tx_busy || brk_state_q == BRK_SEND) &&
                     rx_lvl != txd_q;

   // --------------------------------------------------------------
   // Break detect
   // --------------------------------------------------------------
   // The counter parks at the limit, so one long low reports once.
   assign bkd_lim = char_len_sel ? BKD_TICK_9 : BKD_TICK_8;
   assign bkd_evt = ce && tick && !rx_lvl &&
                    bkd_cnt_q == bkd_lim - 8'h01;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bkd_cnt_q <= 8'h00;
      end else if (ce) begin
         if (!alt_ebc_q[B_BKDON] || !rx_enable || rx_lvl) begin
            bkd_cnt_q <= 8'h00;
         end else if (tick && bkd_cnt_q != bkd_lim) begin
            bkd_cnt_q <= bkd_cnt_q + 8'h01;
         end
      end
   end

   // --------------------------------------------------------------
   // Sticky flags
   // --------------------------------------------------------------
   // A new event beats a clearing write in the same cycle.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_edge_flag_q    <= 1'b0;
         bit_error_flag_q  <= 1'b0;
         bit_error_value_q <= 1'b0;
         break_seen_flag_q <= 1'b0;
      end else if (ce) begin
         if (edge_evt) begin
            rx_edge_flag_q <= 1'b1;
         end else if (wr_stat && wd[B_RXEDG]) begin
            rx_edge_flag_q <= 1'b0;
         end
         if (berr_evt) begin
            bit_error_flag_q  <= 1'b1;
            bit_error_value_q <= rx_lvl;
         end else if (wr_stat && wd[B_BERRF]) begin
            bit_error_flag_q <= 1'b0;
         end
         if (bkd_evt && alt_ebc_q[B_BKDON]) begin
            break_seen_flag_q <= 1'b1;
         end else if (wr_stat && wd[B_BKDF]) begin
            break_seen_flag_q <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // Interrupt request
   // --------------------------------------------------------------
   // Standby silences the receive-full, overrun and idle sources until wakeup.
   always_comb begin
      irq_d = 1'b0;
      irq_d = irq_d || (rx_edge_flag_q && alt_irq_q[B_RXEDIE]);
      irq_d = irq_d || (bit_error_flag_q && alt_irq_q[B_BIT_ERROR_IRQ_EN]);
      irq_d = irq_d || (break_seen_flag_q && alt_irq_q[B_BREAK_SEEN_IRQ_EN]);
      irq_d = irq_d || (tx_empty_flag && ctrl2_q[B_TIE]);
      irq_d = irq_d || (tx_done_flag && ctrl2_q[B_TX_DONE_IRQ_EN]);
      if (rx_enable && !rx_standby) begin
         irq_d = irq_d || ((rx_full_flag || overrun_flag) &&
                           ctrl2_q[B_RIE]);
         irq_d = irq_d || (idle_flag && ctrl2_q[B_IDLE_LINE_IRQ_EN]);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= irq_d;
      end
   end
   assign irq_req = irq_q;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_edge_sets;
      ce && edge_evt |=> rx_edge_flag_q;
   endproperty
   a_edge_sets: assert property (p_edge_sets)
      else $error("Active receive edge did not set the flag.");

   property p_edge_w1c;
      ce && !edge_evt && wr_stat && wd[B_RXEDG] |=> !rx_edge_flag_q;
   endproperty
   a_edge_w1c: assert property (p_edge_w1c)
      else $error("Writing one did not clear the edge flag.");

   property p_berr_value;
      berr_evt |=> bit_error_flag_q && bit_error_value_q != $past(txd_q);
   endproperty
   a_berr_value: assert property (p_berr_value)
      else $error("Bit-error value does not show the mismatch.");

   property p_berr_off;
      bit_error_mode == BERR_OFF || bit_error_mode == BERR_RSVD
         |-> !berr_evt;
   endproperty
   a_berr_off: assert property (p_berr_off)
      else $error("Bit error seen while the check is off.");

   property p_berr_keep;
      ce && bit_error_flag_q && wr_stat && !wd[B_BERRF] |=>
         bit_error_flag_q;
   endproperty
   a_berr_keep: assert property (p_berr_keep)
      else $error("Writing zero cleared the bit-error flag.");

   property p_alt_hidden;
      rd_load && !alt_map_select && idx <= IDX_ALT_EBC |=>
         avs_readdata == 32'h0000_0000;
   endproperty
   a_alt_hidden: assert property (p_alt_hidden)
      else $error("Alternate register readable in normal map.");

   property p_break_low;
      ce && brk_state_q == BRK_SEND && tx_enable |=>
         !txd_pin_o ##0 txd_pin_oe;
   endproperty
   a_break_low: assert property (p_break_low)
      else $error("Transmit pin not low during a break.");

   property p_edge_irq;
      ce && rx_edge_flag_q && alt_irq_q[B_RXEDIE] |=> irq_req;
   endproperty
   a_edge_irq: assert property (p_edge_irq)
      else $error("Enabled edge flag raised no request.");

   // With only receive sources enabled, standby must keep the line low.
   property p_standby_quiet;
      ce && rx_standby && !ctrl2_q[B_TIE] && !ctrl2_q[B_TX_DONE_IRQ_EN] &&
         alt_irq_q == 8'h00 |=> !irq_req;
   endproperty
   a_standby_quiet: assert property (p_standby_quiet)
      else $error("Standby did not silence receive requests.");

   property p_wake_clears;
      ce && wakeup_event && !wr_fire |=> !rx_standby;
   endproperty
   a_wake_clears: assert property (p_wake_clears)
      else $error("Wakeup did not clear receiver standby.");

endmodule : sapsc_top
`default_nettype wire

// [logic/sapsc_pkg.sv]
// Notes on behaviour
// - Active receive edge sets the edge flag.
// - Edge flag clears only on written one.
// - Bit error captures sampled receive level.
// - Mismatch sets bit-error flag, may request interrupt.
// - Bit-error flag clears on written one.
// - Received break sets break flag, may interrupt.
// - Break flag clears on written one.
// - Edge interrupt enable gates edge flag.
// - Bit-error enable gates bit-error flag.
// - Break enable gates break flag request.
// - Mode selects tick nine, thirteen, or off.
// - Break detector runs only when enabled.
// - Alternate registers reachable only in alternate map.
// - Transmit-empty enable gates its request.
// - Transmit-done enable gates its request.
// - Receive-full enable gates full and overrun.
// - Idle-line enable gates idle request.
// - Transmit enable takes transmit pin, queues preamble.
// - Receive enable switches the receiver.
// - Standby blocks receive requests; wakeup clears it.
// - One set-clear of break sends one break.
// - Held break sends whole breaks back to back.
// - Character length and long-break select fix break length.
package sapsc_pkg;

   // ----------------------------------------------------------------
   // Register indices; byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [2:0] IDX_ALT_STAT = 3'h0;
   localparam logic [2:0] IDX_ALT_IRQ  = 3'h1;
   localparam logic [2:0] IDX_ALT_EBC  = 3'h2;
   localparam logic [2:0] IDX_CTRL2    = 3'h3;
   localparam logic [2:0] IDX_AUX      = 3'h4;
   localparam logic [2:0] IDX_STATE    = 3'h5;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int B_RXEDG  = 7;
   localparam int B_BIT_ERROR_VALUE  = 2;
   localparam int B_BERRF  = 1;
   localparam int B_BKDF   = 0;
   localparam int B_RXEDIE = 7;
   localparam int B_BIT_ERROR_IRQ_EN = 1;
   localparam int B_BREAK_SEEN_IRQ_EN  = 0;
   localparam int B_BMODE  = 1;
   localparam int B_BKDON  = 0;
   localparam int B_TIE    = 7;
   localparam int B_TX_DONE_IRQ_EN   = 6;
   localparam int B_RIE    = 5;
   localparam int B_IDLE_LINE_IRQ_EN   = 4;
   localparam int B_TE     = 3;
   localparam int B_RE     = 2;
   localparam int B_RWU    = 1;
   localparam int B_SBK    = 0;
   localparam int B_ALT_MAP_SELECT   = 0;
   localparam int B_RX_POLARITY  = 1;
   localparam int B_CLEN   = 2;
   localparam int B_LBRK   = 3;

   // ----------------------------------------------------------------
   // Reset values and writable masks.
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ALT_IRQ = 8'h00;
   localparam logic [7:0] RST_ALT_EBC = 8'h00;
   localparam logic [7:0] RST_CTRL2   = 8'h00;
   localparam logic [7:0] RST_AUX     = 8'h00;
   localparam logic [7:0] MSK_ALT_IRQ = 8'h83;
   localparam logic [7:0] MSK_ALT_EBC = 8'h07;
   localparam logic [7:0] MSK_AUX     = 8'h0f;

   // ----------------------------------------------------------------
   // Bit timing: ticks per bit, sample ticks, break lengths.
   // ----------------------------------------------------------------
   localparam logic [3:0] TICK_LAST  = 4'hf;
   localparam logic [3:0] TICK_NINE  = 4'h8;
   localparam logic [3:0] TICK_THIRT = 4'hc;
   localparam logic [3:0] BRK_LEN_8  = 4'ha;
   localparam logic [3:0] BRK_LEN_9  = 4'hb;
   localparam logic [3:0] BRK_LONG_8 = 4'hd;
   localparam logic [3:0] BRK_LONG_9 = 4'he;
   localparam logic [7:0] BKD_TICK_8 = 8'ha0;
   localparam logic [7:0] BKD_TICK_9 = 8'hb0;

   typedef enum logic [1:0] {
      BERR_OFF  = 2'b00,
      BERR_T9   = 2'b01,
      BERR_T13  = 2'b10,
      BERR_RSVD = 2'b11
   } sapsc_berr_e;

   typedef enum logic {
      BRK_IDLE = 1'b0,
      BRK_SEND = 1'b1
   } sapsc_brk_e;

endpackage : sapsc_pkg

// [logic/sapsc_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// Divides the bus clock by the baud divisor into sixteenth-bit ticks.
module sapsc_tick_gen (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic        run,
   input  wire logic [12:0] baud_div,
   output logic             tick
);
   import sapsc_pkg::*;

   logic [12:0] cnt_q;

   // --------------------------------------------------------------
   // Divider
   // --------------------------------------------------------------
   // A zero divisor stops the generator, so no tick ever fires.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 13'h0000;
      end else if (ce) begin
         if (!run || baud_div == 13'h0000 || tick) begin
            cnt_q <= 13'h0001;
         end else begin
            cnt_q <= cnt_q + 13'h0001;
         end
      end
   end

   assign tick = run && baud_div != 13'h0000 && cnt_q >= baud_div;

endmodule : sapsc_tick_gen
`default_nettype wire

// [tb/sapsc_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Remote transceiver: rests at mark level, can send a long space.
// ------------------------------------------------------------------
module sapsc_far_end (
   input  wire logic clk_sys,
   output var logic  rxd_pin
);
   // An idle line rests at mark, as a pulled-up serial wire would.
   initial rxd_pin = 1'b1;

   // Hold a space for n clocks; the rising end is not an active edge.
   task automatic send_low(input int n);
      @(posedge clk_sys);
      rxd_pin <= 1'b0;
      repeat (n) @(posedge clk_sys);
      rxd_pin <= 1'b1;
   endtask : send_low
endmodule : sapsc_far_end
`default_nettype wire

// [tb/sapsc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sapsc_top_bench;
   import sapsc_pkg::*;
   logic        clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0]  avs_byteenable = 4'hf;
   logic        avs_waitrequest, rxd_pin, txd_pin_o, txd_pin_oe;
   logic [12:0] baud_div = 13'h0001;
   logic        tx_data_bit = 1'b1, tx_busy = 1'b0, tx_empty_flag = 1'b0;
   logic        tx_done_flag = 1'b0, rx_full_flag = 1'b0;
   logic        overrun_flag = 1'b0, idle_flag = 1'b0, wakeup_event = 1'b0;
   logic        bit_strobe, tx_enable, rx_enable, rx_standby;
   logic        idle_preamble_req, irq_req;
   int          error_cnt = 0, cmp_count = 0, low_cnt = 0, stb_cnt = 0;

   // ---------------------------------------------------------------
   // Clock, design and far end.
   // ---------------------------------------------------------------
   always #4 clk_sys = ~clk_sys;

   sapsc_top sapsc_top_i (.clk_sys, .resetn, .ce, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .rxd_pin, .txd_pin_o, .txd_pin_oe, .baud_div,
      .tx_data_bit, .tx_busy, .tx_empty_flag, .tx_done_flag, .rx_full_flag,
      .overrun_flag, .idle_flag, .wakeup_event, .bit_strobe, .tx_enable,
      .rx_enable, .rx_standby, .idle_preamble_req, .irq_req);

   sapsc_far_end sapsc_far_end_i (.clk_sys, .rxd_pin);

   // Counts clocks of space on the transmit pin, and bit strobes in it.
   always @(negedge clk_sys) begin
      if (txd_pin_o === 1'b0) low_cnt++;
      if (txd_pin_o === 1'b0 && bit_strobe === 1'b1) stb_cnt++;
   end

   // ---------------------------------------------------------------
   // Bus access, compare and closing.
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Request stands until the edge at which waitrequest is seen low.
   task automatic acc(input logic rw, input logic [2:0] idx,
                      input logic [7:0] wd, output logic [31:0] rdv);
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, wd};
      avs_read <= ~rw;
      avs_write <= rw;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : acc

   task automatic wr(input logic [2:0] idx, input logic [7:0] wd);
      logic [31:0] dummy;
      acc(1'b1, idx, wd, dummy);
   endtask : wr

   task automatic rc(input logic [2:0] idx, input logic [31:0] exp);
      logic [31:0] v;
      acc(1'b0, idx, 8'h00, v);
      chk(v, exp);
   endtask : rc

   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   // The tests need about eight hundred clocks; twenty-five times that is a hang.
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      test_done();
   end

   // ---------------------------------------------------------------
   // Tests.
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      wr(IDX_ALT_IRQ, 8'hff);
      rc(IDX_ALT_IRQ, 32'h0);
      rc(IDX_CTRL2, 32'h0);
      wr(IDX_AUX, 8'h01);
      rc(IDX_ALT_IRQ, 32'h0);
      $display("map test done");
      // A long space gives both an active edge and a received break.
      wr(IDX_CTRL2, 8'h04);
      wr(IDX_ALT_EBC, 8'h01);
      wr(IDX_ALT_IRQ, 8'h81);
      rc(IDX_ALT_IRQ, 32'h81);
      sapsc_far_end_i.send_low(200);
      repeat (4) @(posedge clk_sys);
      rc(IDX_ALT_STAT, 32'h81);
      chk({31'h0, irq_req}, 32'h1);
      wr(IDX_ALT_STAT, 8'h00);
      rc(IDX_ALT_STAT, 32'h81);
      wr(IDX_ALT_STAT, 8'h81);
      rc(IDX_ALT_STAT, 32'h00);
      chk({31'h0, irq_req}, 32'h0);
      $display("edge and break test done");
      // One break of ten bit times while the line reads back mark.
      wr(IDX_ALT_EBC, 8'h02);
      low_cnt = 0;
      stb_cnt = 0;
      wr(IDX_CTRL2, 8'h0d);
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk({30'h0, tx_enable, rx_enable}, 32'h3);
      chk({30'h0, txd_pin_oe, idle_preamble_req}, 32'h3);
      @(negedge clk_sys);
      chk({31'h0, idle_preamble_req}, 32'h0);
      while (txd_pin_o !== 1'b0) @(negedge clk_sys);
      wr(IDX_CTRL2, 8'h0c);
      while (txd_pin_o !== 1'b1) @(negedge clk_sys);
      repeat (40) @(negedge clk_sys);
      chk(low_cnt, 32'd160);
      chk(stb_cnt, 32'd10);
      rc(IDX_ALT_STAT, 32'h06);
      chk({31'h0, irq_req}, 32'h0);
      // Nine-bit characters with long breaks give fourteen bit times,
      // checked at the thirteenth tick this time.
      wr(IDX_AUX, 8'h0d);
      wr(IDX_ALT_STAT, 8'h06);
      wr(IDX_ALT_EBC, 8'h04);
      low_cnt = 0;
      wr(IDX_CTRL2, 8'h0d);
      while (txd_pin_o !== 1'b0) @(negedge clk_sys);
      wr(IDX_CTRL2, 8'h0c);
      while (txd_pin_o !== 1'b1) @(negedge clk_sys);
      repeat (40) @(negedge clk_sys);
      chk(low_cnt, 32'd224);
      rc(IDX_ALT_STAT, 32'h06);
      $display("break test done");
      // Receive-full request, then standby blocks it until wakeup.
      wr(IDX_CTRL2, 8'h24);
      rx_full_flag <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk({31'h0, irq_req}, 32'h1);
      wr(IDX_CTRL2, 8'h26);
      repeat (2) @(negedge clk_sys);
      chk({31'h0, irq_req}, 32'h0);
      @(posedge clk_sys);
      wakeup_event <= 1'b1;
      @(posedge clk_sys);
      wakeup_event <= 1'b0;
      @(negedge clk_sys);
      chk({31'h0, rx_standby}, 32'h0);
      $display("receive request test done");
      test_done();
   end
endmodule : sapsc_top_bench
`default_nettype wire
